// ==== rtl/bcfg_map.vh ====
// register offsets, fixed field values and reset values of the configuration header block
// assumes byte addressing over a 32-bit register bus
`ifndef BCFG_MAP_VH
`define BCFG_MAP_VH

`define BCFG_OFF_CACHE      8'h0C
`define BCFG_OFF_IO_BASE    8'h10
`define BCFG_OFF_MEM_BASE   8'h14
`define BCFG_OFF_SUBSYS     8'h2C
`define BCFG_OFF_CAP_PTR    8'h34
`define BCFG_OFF_INTR       8'h3C
`define BCFG_OFF_PM_CAP     8'h80
`define BCFG_OFF_LOAD       8'hC0

`define BCFG_RST_CACHE      8'h00
`define BCFG_RST_INTR_LINE  8'h00
`define BCFG_INTR_PIN       8'h01
`define BCFG_LAT_TIMER      8'h00
`define BCFG_HDR_TYPE       8'h00
`define BCFG_RST_IO_BASE    32'h00000001
`define BCFG_RST_MEM_BASE   32'h00000000
`define BCFG_RST_CAP_PTR    8'h80
`define BCFG_PM_CAP_ID      8'h01
`define BCFG_PM_NEXT        8'h8C
`define BCFG_PM_REV         3'h3
`define BCFG_PM_EVCLK       1'h0
`define BCFG_PM_AUXPWR      1'h1
`define BCFG_RST_PM_DSI     1'h0
`define BCFG_RST_PM_AUXCUR  3'h7
`define BCFG_RST_PM_D1      1'h1
`define BCFG_RST_PM_D2      1'h1
`define BCFG_RST_PM_WAKE    5'h08

`define BCFG_IO_WIN_BYTES   64
`define BCFG_MEM_WIN_BYTES  4096
`define BCFG_IO_TYPE_BIT    32'h00000001

`define BCFG_RESP_OKAY      2'h0
`define BCFG_RESP_SLVERR    2'h2

`endif

// ==== rtl/bcfg_header.v ====
// configuration header registers of the serial-port bridge function, AXI4-Lite slave
// assumes one clock, synchronous active-low reset, and an auto-load source that
// presents loaded values with a one-cycle load strobe after reset
// and a bus master that keeps each request steady until it is taken
// Operation
// - cache line size is 8-bit RW, resets zero, affects nothing.
// - latency timer bits 15:8 read zero, writes ignored.
// - header type bits 23:16 read zero, read only.
// - I/O base is RW, 64-byte window, resets to 00000001h.
// - memory base is RW, 4096-byte window, resets to zero.
// - subsystem vendor code bits 15:0 read only, replaced by auto-load.
// - subsystem device code bits 31:16 read only, replaced by auto-load.
// - capability list start defaults to 80h, replaced by auto-load.
// - interrupt routing byte is RW, resets zero, written by startup software.
// - legacy interrupt select bits 15:8 read 01h.
// - power capability identifier at 80h reads 01h.
// - power capability next link bits 15:8 read 8Ch.
// - power management revision bits 18:16 read 011b.
// - event clock flag bit 19 reads zero.
// - auxiliary power bit 20 reads one.
// - device specific init bit 21 defaults zero, replaced by auto-load.
// - auxiliary current bits 24:22 default 111b, replaced by auto-load.
// - D1 support bit 25 defaults one, replaced by auto-load.
// - D2 support bit 26 defaults one, replaced by auto-load.
// - wake support bits 31:27 default 01000b, replaced by auto-load.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "bcfg_map.vh"

module bcfg_header #(
	parameter [15:0] SUBSYS_VENDOR_DEFAULT = 16'h5A5A, // arbitrary
	parameter [15:0] SUBSYS_DEVICE_DEFAULT = 16'hA5A5  // arbitrary
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        load_strobe,
	input  wire [15:0] load_subsys_vendor,
	input  wire [15:0] load_subsys_device,
	input  wire [7:0]  load_cap_list_start,
	input  wire [10:0] load_power_caps,
	output reg  [31:0] io_window_base,
	output reg  [31:0] memory_window_base,
	output reg  [7:0]  interrupt_routing
);

	localparam [31:0] IO_MASK  = ~(`BCFG_IO_WIN_BYTES - 1);
	localparam [31:0] MEM_MASK = ~(`BCFG_MEM_WIN_BYTES - 1);

	// storage
	reg  [7:0]  cache_line_size_q;
	reg  [15:0] subsys_vendor_q;
	reg  [15:0] subsys_device_q;
	reg  [7:0]  cap_list_start_q;
	reg         pm_dsi_q;
	reg  [2:0]  pm_auxcur_q;
	reg         pm_d1_q;
	reg         pm_d2_q;
	reg  [4:0]  pm_wake_q;
	reg         loaded_q;

	// write channel capture
	reg  [7:0]  aw_addr_q;
	reg         aw_have_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	reg         w_have_q;
	wire        do_write;

	// byte-lane merge of a write into an old value
	function [31:0] bcfg_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  strb;
		integer      i;
		begin
			bcfg_merge = old_v;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					bcfg_merge[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
	endfunction

	// address decode shared by read and write paths
	function bcfg_mapped;
		input [7:0] a;
		begin
			case ({a[7:2], 2'b00})
				`BCFG_OFF_CACHE, `BCFG_OFF_IO_BASE, `BCFG_OFF_MEM_BASE,
				`BCFG_OFF_SUBSYS, `BCFG_OFF_CAP_PTR, `BCFG_OFF_INTR,
				`BCFG_OFF_PM_CAP, `BCFG_OFF_LOAD: bcfg_mapped = 1'b1;
				default: bcfg_mapped = 1'b0;
			endcase
		end
	endfunction

	// word-aligned offset; the two low address bits never select a register
	function [7:0] bcfg_word_offset;
		input [7:0] a;
		begin
			bcfg_word_offset = {a[7:2], 2'b00};
		end
	endfunction

	// base register write: merge lanes, then pin the bits below the window
	function [31:0] bcfg_bar_next;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  strb;
		input [31:0] mask;
		input [31:0] fixed_bits;
		begin
			bcfg_bar_next = (bcfg_merge(old_v, new_v, strb) & mask) | fixed_bits;
		end
	endfunction

	assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

	// one write enable per software-writable word
	wire [7:0]  wr_offset = bcfg_word_offset(aw_addr_q);
	wire        wr_cache  = do_write && (wr_offset == `BCFG_OFF_CACHE);
	wire        wr_io     = do_write && (wr_offset == `BCFG_OFF_IO_BASE);
	wire        wr_mem    = do_write && (wr_offset == `BCFG_OFF_MEM_BASE);
	wire        wr_intr   = do_write && (wr_offset == `BCFG_OFF_INTR);

	// response codes; unmapped offsets answer with a slave error
	wire [1:0]  wr_resp = bcfg_mapped(aw_addr_q) ? `BCFG_RESP_OKAY : `BCFG_RESP_SLVERR;
	wire [1:0]  rd_resp = bcfg_mapped(s_axi_araddr) ? `BCFG_RESP_OKAY : `BCFG_RESP_SLVERR;

	// fixed fields; software writes never reach them
	wire [7:0]  latency_timer      = `BCFG_LAT_TIMER;
	wire [7:0]  header_layout_type = `BCFG_HDR_TYPE;
	wire [7:0]  legacy_intr_select = `BCFG_INTR_PIN;
	wire [7:0]  pm_cap_id          = `BCFG_PM_CAP_ID;
	wire [7:0]  pm_next_link       = `BCFG_PM_NEXT;
	wire [2:0]  pm_revision        = `BCFG_PM_REV;
	wire        pm_event_clock     = `BCFG_PM_EVCLK;
	wire        pm_aux_power       = `BCFG_PM_AUXPWR;

	// auto-load word split into the power capability fields 31:21
	wire [4:0]  load_wake   = load_power_caps[10:6];
	wire        load_d2     = load_power_caps[5];
	wire        load_d1     = load_power_caps[4];
	wire [2:0]  load_auxcur = load_power_caps[3:1];
	wire        load_dsi    = load_power_caps[0];

	// whole read words, one per mapped offset
	wire [31:0] word_cache;
	wire [31:0] word_io;
	wire [31:0] word_mem;
	wire [31:0] word_subsys;
	wire [31:0] word_cap;
	wire [31:0] word_intr;
	wire [31:0] word_pm;
	wire [31:0] word_load;

	assign word_cache = {
		8'h00,
		header_layout_type,
		latency_timer,
		cache_line_size_q
	};

	// base registers read back as stored; the write path pins their low bits
	assign word_io  = io_window_base;
	assign word_mem = memory_window_base;

	assign word_subsys = {
		subsys_device_q,
		subsys_vendor_q
	};

	assign word_cap = {
		24'h000000,
		cap_list_start_q
	};

	assign word_intr = {
		16'h0000,
		legacy_intr_select,
		interrupt_routing
	};

	// bits 31:21 are loadable, bits 20:0 are fixed
	assign word_pm = {
		pm_wake_q,
		pm_d2_q,
		pm_d1_q,
		pm_auxcur_q,
		pm_dsi_q,
		pm_aux_power,
		pm_event_clock,
		pm_revision,
		pm_next_link,
		pm_cap_id
	};

	assign word_load = {
		31'h00000000,
		loaded_q
	};

	// next values of the software-writable fields
	reg  [7:0]  cache_line_size_d;
	reg  [31:0] io_window_base_d;
	reg  [31:0] memory_window_base_d;
	reg  [7:0]  interrupt_routing_d;

	always @* begin
		cache_line_size_d    = cache_line_size_q;
		io_window_base_d     = io_window_base;
		memory_window_base_d = memory_window_base;
		interrupt_routing_d  = interrupt_routing;
		// only the low byte stores; latency and header bytes stay fixed
		if (wr_cache && w_strb_q[0]) begin
			cache_line_size_d = w_data_q[7:0];
		end
		// low bits pinned so an all-ones write reads back the window size
		if (wr_io) begin
			io_window_base_d = bcfg_bar_next(io_window_base, w_data_q, w_strb_q,
				IO_MASK, `BCFG_IO_TYPE_BIT);
		end
		if (wr_mem) begin
			memory_window_base_d = bcfg_bar_next(memory_window_base, w_data_q, w_strb_q,
				MEM_MASK, 32'h00000000);
		end
		if (wr_intr && w_strb_q[0]) begin
			interrupt_routing_d = w_data_q[7:0];
		end
	end

	// read word chosen by the request's offset; unmapped offsets read zero
	reg  [31:0] rdata_d;

	always @* begin
		rdata_d = 32'h00000000;
		case (bcfg_word_offset(s_axi_araddr))
			`BCFG_OFF_CACHE:
				rdata_d = word_cache;
			`BCFG_OFF_IO_BASE:
				rdata_d = word_io;
			`BCFG_OFF_MEM_BASE:
				rdata_d = word_mem;
			`BCFG_OFF_SUBSYS:
				rdata_d = word_subsys;
			`BCFG_OFF_CAP_PTR:
				rdata_d = word_cap;
			`BCFG_OFF_INTR:
				rdata_d = word_intr;
			`BCFG_OFF_PM_CAP:
				rdata_d = word_pm;
			`BCFG_OFF_LOAD:
				rdata_d = word_load;
			default:
				rdata_d = 32'h00000000;
		endcase
	end

	// address and data accepted independently; response once both are held
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `BCFG_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_have_q && !s_axi_wready && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_resp;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// software-writable fields; the three outputs come straight from these flops
	always @(posedge aclk) begin
		if (!aresetn) begin
			cache_line_size_q  <= `BCFG_RST_CACHE;
			io_window_base     <= `BCFG_RST_IO_BASE;
			memory_window_base <= `BCFG_RST_MEM_BASE;
			interrupt_routing  <= `BCFG_RST_INTR_LINE;
		end else begin
			cache_line_size_q  <= cache_line_size_d;
			io_window_base     <= io_window_base_d;
			memory_window_base <= memory_window_base_d;
			interrupt_routing  <= interrupt_routing_d;
		end
	end

	// read-only defaults, replaced whenever the auto-load strobe fires
	always @(posedge aclk) begin
		if (!aresetn) begin
			subsys_vendor_q  <= SUBSYS_VENDOR_DEFAULT;
			subsys_device_q  <= SUBSYS_DEVICE_DEFAULT;
			cap_list_start_q <= `BCFG_RST_CAP_PTR;
			pm_dsi_q         <= `BCFG_RST_PM_DSI;
			pm_auxcur_q      <= `BCFG_RST_PM_AUXCUR;
			pm_d1_q          <= `BCFG_RST_PM_D1;
			pm_d2_q          <= `BCFG_RST_PM_D2;
			pm_wake_q        <= `BCFG_RST_PM_WAKE;
			loaded_q         <= 1'b0;
		end else begin
			// first running cycle: software can tell the defaults are live
			loaded_q <= 1'b1;
			if (load_strobe) begin
				subsys_vendor_q  <= load_subsys_vendor;
				subsys_device_q  <= load_subsys_device;
				cap_list_start_q <= load_cap_list_start;
				pm_dsi_q         <= load_dsi;
				pm_auxcur_q      <= load_auxcur;
				pm_d1_q          <= load_d1;
				pm_d2_q          <= load_d2;
				pm_wake_q        <= load_wake;
			end
		end
	end

	// read path, one read at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `BCFG_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= rd_resp;
				s_axi_rdata   <= rdata_d;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// ==== test/bcfg_header_properties.sv ====
// checker of read answers and register outputs of the header block
// assumes only the ports of bcfg_header, one clock, sync low reset
`timescale 1ns/1ps
module bcfg_props (
	input wire        aclk,
	input wire        aresetn,
	input wire [7:0]  s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_bvalid,
	input wire [31:0] io_window_base,
	input wire [31:0] memory_window_base,
	input wire [7:0]  interrupt_routing
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	rst_vals_a: assert property ($rose(aresetn) |-> io_window_base == 32'h00000001 &&
		memory_window_base == 32'h00000000 && interrupt_routing == 8'h00) else $error("bad reset");
	io_size_a: assert property (io_window_base[5:0] == 6'h01) else $error("io base low bits");
	mem_size_a: assert property (memory_window_base[11:0] == 12'h000) else $error("mem low bits");
	store_time_a: assert property ($changed(io_window_base) || $changed(memory_window_base) ||
		$changed(interrupt_routing) |-> $rose(s_axi_bvalid)) else $error("store off response");
	hdr_ro_a: assert property (ar_hs && s_axi_araddr == 8'h0C |-> ##[1:2]
		s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000) else $error("header byte not zero");
	pin_ro_a: assert property (ar_hs && s_axi_araddr == 8'h3C |-> ##[1:2]
		s_axi_rvalid && s_axi_rdata[31:8] == 24'h000001) else $error("pin byte wrong");
	pm_ro_a: assert property (ar_hs && s_axi_araddr == 8'h80 |-> ##[1:2]
		s_axi_rvalid && s_axi_rdata[20:0] == 21'h138C01) else $error("pm fixed bits wrong");
	io_read_a: assert property (ar_hs && s_axi_araddr == 8'h10 |-> ##[1:2]
		s_axi_rvalid && s_axi_rdata == io_window_base) else $error("io base read");
	mem_read_a: assert property (ar_hs && s_axi_araddr == 8'h14 |-> ##[1:2]
		s_axi_rvalid && s_axi_rdata == memory_window_base) else $error("mem base read");
endmodule
bind bcfg_header bcfg_props u_props (.*);

// ==== test/bcfg_host.sv ====
// config software stand-in: AXI4-Lite master, one write task, one read task
// assumes an answer within 40 cycles; a miss bumps hang
`timescale 1ns/1ps
module bcfg_host (
	input wire        aclk,
	input wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
	input wire [1:0]  s_axi_bresp, s_axi_rresp,
	input wire [31:0] s_axi_rdata,
	output reg [7:0]  s_axi_awaddr, s_axi_araddr,
	output reg [31:0] s_axi_wdata,
	output reg [3:0]  s_axi_wstrb,
	output reg        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready
);
	integer hang = 0;
	initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
	initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
	// released address and data lines are inverted so a stale value is never mistaken for payload
	task wr(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
		integer n;
		begin
			r = 2'h1;
			@(posedge aclk);
			{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
			for (n = 0; n < 40 && r === 2'h1; n = n + 1) begin
				@(posedge aclk);
				if (s_axi_awready && s_axi_awvalid)
					{s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
				if (s_axi_wready && s_axi_wvalid)
					{s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
				if (s_axi_bvalid && s_axi_bready) begin
					r = s_axi_bresp;
					s_axi_bready <= 1'b0;
				end
			end
			if (r === 2'h1)
				hang = hang + 1;
		end
	endtask
	task rd(input [7:0] a, output [31:0] d, output [1:0] r);
		integer n;
		begin
			r = 2'h1;
			@(posedge aclk);
			{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
			for (n = 0; n < 40 && r === 2'h1; n = n + 1) begin
				@(posedge aclk);
				if (s_axi_arready && s_axi_arvalid)
					{s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
				if (s_axi_rvalid && s_axi_rready) begin
					{d, r} = {s_axi_rdata, s_axi_rresp};
					s_axi_rready <= 1'b0;
				end
			end
			if (r === 2'h1)
				hang = hang + 1;
		end
	endtask
endmodule

// ==== test/tb_bridge_config_header_pm_cap.sv ====
// self-checking bench of the header block: read table, write table, load, second reset
// assumes bcfg_host as bus master and the default subsystem parameters
`timescale 1ns/1ps
module tb_bridge_config_header_pm_cap;
	reg         aclk = 1'b0, aresetn = 1'b0, load_strobe = 1'b0;
	reg  [15:0] load_subsys_vendor = 16'h1234, load_subsys_device = 16'hABCD;
	reg  [7:0]  load_cap_list_start = 8'h40;
	reg  [10:0] load_power_caps = 11'h7FF;
	wire [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [7:0]  s_axi_awaddr, s_axi_araddr, interrupt_routing;
	wire [3:0]  s_axi_wstrb;
	wire [31:0] s_axi_wdata, s_axi_rdata, io_window_base, memory_window_base;
	reg  [41:0] rrow [0:7];
	reg  [75:0] wrow [0:6];
	reg  [31:0] d;
	reg  [1:0]  r;
	integer     i, err_total = 0, n_checks = 0;
	bcfg_header uut (.*);
	bcfg_host u_host (.*);
	always #25 aclk = ~aclk;
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task close_out;
		begin
			err_total = err_total + u_host.hang;
			$display("checks %0d errors %0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task rchk(input [7:0] a, input [31:0] e, input [1:0] er);
		begin
			u_host.rd(a, d, r);
			if (u_host.hang != 0)
				close_out;
			chk(d, e);
			chk({30'h0, r}, {30'h0, er});
		end
	endtask
	task run_rows;
		for (i = 0; i < 8; i = i + 1)
			rchk(rrow[i][41:34], rrow[i][33:2], rrow[i][1:0]);
	endtask
	initial begin
		rrow[0] = {8'h0C, 32'h00000000, 2'h0};
		rrow[1] = {8'h10, 32'h00000001, 2'h0};
		rrow[2] = {8'h14, 32'h00000000, 2'h0};
		rrow[3] = {8'h2C, 32'hA5A55A5A, 2'h0};
		rrow[4] = {8'h34, 32'h00000080, 2'h0};
		rrow[5] = {8'h3C, 32'h00000100, 2'h0};
		rrow[6] = {8'h80, 32'h47D38C01, 2'h0};
		rrow[7] = {8'h40, 32'h00000000, 2'h2};
		wrow[0] = {8'h0C, 32'hFFFFFFFF, 4'hF, 32'h000000FF};
		wrow[1] = {8'h0C, 32'h00000000, 4'hE, 32'h000000FF};
		wrow[2] = {8'h10, 32'hFFFFFFFF, 4'hF, 32'hFFFFFFC1};
		wrow[3] = {8'h14, 32'hFFFFFFFF, 4'hF, 32'hFFFFF000};
		wrow[4] = {8'h3C, 32'hFFFFFFFF, 4'hF, 32'h000001FF};
		wrow[5] = {8'h2C, 32'h00000000, 4'hF, 32'hA5A55A5A};
		wrow[6] = {8'h80, 32'h00000000, 4'hF, 32'h47D38C01};
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		run_rows;
		for (i = 0; i < 7; i = i + 1) begin
			u_host.wr(wrow[i][75:68], wrow[i][67:36], wrow[i][35:32], r);
			rchk(wrow[i][75:68], wrow[i][31:0], 2'h0);
		end
		chk({24'h0, interrupt_routing}, 32'h000000FF);
		u_host.wr(8'h40, 32'hFFFFFFFF, 4'hF, r);
		chk({30'h0, r}, 32'h00000002);
		@(posedge aclk);
		{load_strobe, load_power_caps} <= {1'b1, 11'h155};
		@(posedge aclk);
		load_strobe <= 1'b0;
		rchk(8'h2C, 32'hABCD1234, 2'h0);
		rchk(8'h34, 32'h00000040, 2'h0);
		u_host.rd(8'h80, d, r);
		chk({11'h0, d[20:0]}, 32'h00138C01);
		chk({21'h0, d[31:21]}, 32'h00000155);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		run_rows;
		close_out;
	end
endmodule
